// >>> hw/tsiu_core.v
// Timer, serial port and interrupt priority unit of an 8-bit controller.
`timescale 1ns/1ps
`include "tsiu_defines.vh"
module tsiu_core (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // CPU core
  input wire disable_flag,
  input wire break_instruction,
  input wire stop_instruction,
  input wire int_ack,
  output wire int_pending,
  output reg [15:0] int_vector,
  output reg break_flag,
  output wire set_disable,
  // Pins
  input wire ext_one_pin,
  input wire ext_two_pin,
  input wire external_count_input,
  input wire ser_clk_in,
  output reg ser_clk_out,
  output wire ser_clk_oe,
  input wire ser_din,
  output reg ser_dout,
  output wire ser_dout_oe,
  output reg ser_rdy_n,
  output wire ser_rdy_oe
);
  // ----------------------------------------
  // Registers and helpers
  // ----------------------------------------
  reg [7:0] edge_mode_r;
  reg [7:0] ser_mode_r;
  reg [7:0] int_ctrl_r;
  reg [7:0] timer_setup_r;
  reg [7:0] latch_r [0:2];
  reg [7:0] cnt_r [0:2];
  reg [7:0] shift_r;
  reg [2:0] bit_cnt_r;
  reg ser_busy_r;
  reg ser_done_r;
  reg chain_r;
  reg [1:0] phi_div_r;
  reg ser_int_div_r;
  reg [2:0] s1_r, s2_r, s3_r;
  reg [2:0] sync_prev_r;
  reg sclk_prev_r;
  reg [2:0] zero_r;
  wire [2:0] tick;
  wire [2:0] zero_now;
  reg [3:0] req_set;
  reg [7:0] int_ctrl_nxt;

  function wr_hit;
    input [7:0] ofs;
    begin
      wr_hit = reg_wr && (reg_addr == ofs);
    end
  endfunction

  // Edge qualifier: returns a pulse once the later two stages agree on a new level that equals pol.
  function edge_seen;
    input cur;
    input prev;
    input pol;
    begin
      edge_seen = (cur != prev) && (cur == pol);
    end
  endfunction

  wire serial_en = ser_mode_r[`TSIU_SM_SERIAL_EN_BIT];
  wire [1:0] clk_sel = ser_mode_r[`TSIU_SM_CLKSEL_HI:`TSIU_SM_CLKSEL_LO];
  wire int_clk = clk_sel[1];
  wire phi4 = (phi_div_r == `TSIU_PHI_DIV);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire [2:0] pins = {external_count_input, ext_two_pin, ext_one_pin};
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      s3_r <= 3'h0;
      sync_prev_r <= 3'h0;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r[0] == s3_r[0]) sync_prev_r[0] <= s3_r[0];
      if (s2_r[1] == s3_r[1]) sync_prev_r[1] <= s3_r[1];
      if (s2_r[2] == s3_r[2]) sync_prev_r[2] <= s3_r[2];
    end
  end
  wire [2:0] stable = ~(s2_r ^ s3_r);
  wire ext1_ev = stable[0] &&
    edge_seen(s3_r[0], sync_prev_r[0], edge_mode_r[`TSIU_EXT1_POL_BIT]);
  wire ext2_ev = stable[1] &&
    edge_seen(s3_r[1], sync_prev_r[1], edge_mode_r[`TSIU_EXT2_POL_BIT]);
  wire external_count_input_ev = stable[2] && edge_seen(s3_r[2], sync_prev_r[2], 1'b0);

  // Shift clock synchroniser shares the same three-stage scheme.
  reg sc1_r, sc2_r, sc3_r;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sc1_r <= 1'b1;
      sc2_r <= 1'b1;
      sc3_r <= 1'b1;
    end else begin
      sc1_r <= ser_clk_in;
      sc2_r <= sc1_r;
      sc3_r <= sc2_r;
    end
  end

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  assign tick[0] = timer_setup_r[`TSIU_TS_T1_SRC_BIT] ? zero_r[1] : phi4;
  assign tick[1] = chain_r ? phi4 :
    (!timer_setup_r[`TSIU_TS_T2_HALT_BIT] &&
     (timer_setup_r[`TSIU_TS_T2_SRC_BIT] ? zero_r[0] : phi4));
  assign tick[2] = chain_r ? zero_r[1] :
    (timer_setup_r[`TSIU_TS_T3_SRC_BIT] ? external_count_input_ev : zero_r[1]);

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_tmr
      // The three timer latches sit at consecutive offsets.
      localparam integer TMR_OFS = `TSIU_OFS_TIMER1 + gi;
      assign zero_now[gi] = tick[gi] && (cnt_r[gi] == 8'h00);
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          cnt_r[gi] <= (gi == 0) ? `TSIU_REG_RST :
            (gi == 1) ? `TSIU_T2_LATCH_RST : `TSIU_T3_LATCH_RST;
          latch_r[gi] <= (gi == 0) ? `TSIU_REG_RST :
            (gi == 1) ? `TSIU_T2_LATCH_RST : `TSIU_T3_LATCH_RST;
          zero_r[gi] <= 1'b0;
        end else begin
          zero_r[gi] <= zero_now[gi];
          if (stop_instruction && gi != 0) begin
            latch_r[gi] <= (gi == 1) ? `TSIU_T2_LATCH_RST : `TSIU_T3_LATCH_RST;
            cnt_r[gi] <= (gi == 1) ? `TSIU_T2_LATCH_RST : `TSIU_T3_LATCH_RST;
          end else if (wr_hit(TMR_OFS[7:0])) begin
            latch_r[gi] <= reg_wdata;
            cnt_r[gi] <= reg_wdata;
          end else if (tick[gi]) begin
            // Reload on the tick after zero gives a 1/(n+1) division.
            cnt_r[gi] <= (cnt_r[gi] == 8'h00) ? latch_r[gi] : cnt_r[gi] - 8'h01;
          end
        end
      end
    end
  endgenerate

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phi_div_r <= 2'h0;
      chain_r <= 1'b0;
    end else begin
      phi_div_r <= phi_div_r + 2'h1;
      if (stop_instruction) chain_r <= 1'b1;
      else if (req_set[1]) chain_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Serial port
  // ----------------------------------------
  wire int_src = (clk_sel == 2'h3) ? phi4 : (zero_r[0] && ser_int_div_r);
  wire ext_fall = !int_clk && sclk_prev_r && !sc3_r && (sc2_r == sc3_r);
  wire ext_rise = !int_clk && !sclk_prev_r && sc3_r && (sc2_r == sc3_r);
  wire int_fall = int_clk && ser_busy_r && int_src && ser_clk_out;
  wire int_rise = int_clk && int_src && !ser_clk_out;
  wire s_fall = serial_en && (int_fall || ext_fall);
  wire s_rise = serial_en && (int_rise || ext_rise);
  wire data_wr = wr_hit(`TSIU_OFS_SER_DATA);

  assign ser_clk_oe = serial_en && int_clk;
  assign ser_dout_oe = serial_en;
  assign ser_rdy_oe = ser_mode_r[`TSIU_SM_RDY_EN_BIT];

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      ser_busy_r <= 1'b0;
      ser_done_r <= 1'b0;
      ser_clk_out <= 1'b1;
      ser_dout <= 1'b1;
      ser_rdy_n <= 1'b1;
      sclk_prev_r <= 1'b1;
      ser_int_div_r <= 1'b0;
    end else begin
      ser_done_r <= 1'b0;
      if (sc2_r == sc3_r) sclk_prev_r <= sc3_r;
      if (zero_r[0]) ser_int_div_r <= !ser_int_div_r;
      if (int_fall) ser_clk_out <= 1'b0;
      else if (int_rise) ser_clk_out <= 1'b1;
      if (data_wr) begin
        shift_r <= reg_wdata;
        bit_cnt_r <= `TSIU_SER_CNT_LOAD;
        ser_busy_r <= 1'b1;
        ser_rdy_n <= 1'b0;
      end else begin
        if (s_fall) begin
          ser_dout <= shift_r[0];
          ser_rdy_n <= 1'b1;
        end
        if (s_rise && ser_busy_r) begin
          shift_r <= {ser_din, shift_r[7:1]};
          bit_cnt_r <= bit_cnt_r - 3'h1;
          if (bit_cnt_r == 3'h0) begin
            ser_busy_r <= 1'b0;
            ser_done_r <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Interrupt requests and priority
  // ----------------------------------------
  wire [3:0] en = int_ctrl_r[7:4];
  wire [3:0] req = int_ctrl_r[3:0];
  wire [3:0] live = en & req & {4{!disable_flag}};
  reg [1:0] pick;

  always @* begin
    // Bits: 0 ext1, 1 timer3, 2 timer2, 3 timer1 or serial; ext2 is held in the setup register below.
    req_set = 4'h0;
    req_set[0] = ext1_ev;
    req_set[1] = zero_r[2];
    req_set[2] = zero_r[1];
    req_set[3] = serial_en ? ser_done_r : zero_r[0];
    pick = 2'h0;
    if (live[0]) pick = 2'h0;
    else if (live[1]) pick = 2'h1;
    else if (live[2]) pick = 2'h2;
    else pick = 2'h3;
  end

  // Ext2 request lives in the setup register's spare bit 6, its enable in spare bit 7.
  wire ext2_live = timer_setup_r[7] && timer_setup_r[6] && !disable_flag;
  assign int_pending = (|live) || ext2_live || break_instruction;
  assign set_disable = int_ack;

  always @* begin
    int_ctrl_nxt = int_ctrl_r;
    if (wr_hit(`TSIU_OFS_INT_CTRL)) begin
      int_ctrl_nxt[7:4] = reg_wdata[7:4];
      int_ctrl_nxt[3:0] = int_ctrl_r[3:0] & reg_wdata[3:0];
    end
    if (int_ack && |live) int_ctrl_nxt[pick] = 1'b0;
    int_ctrl_nxt[3:0] = int_ctrl_nxt[3:0] | req_set; // Set wins over clear.
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      edge_mode_r <= `TSIU_REG_RST;
      ser_mode_r <= `TSIU_REG_RST;
      int_ctrl_r <= `TSIU_REG_RST;
      timer_setup_r <= `TSIU_REG_RST;
      int_vector <= `TSIU_VEC_RESET;
      break_flag <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      int_ctrl_r <= int_ctrl_nxt;
      if (wr_hit(`TSIU_OFS_EDGE_MODE)) edge_mode_r <= reg_wdata;
      if (wr_hit(`TSIU_OFS_SER_MODE)) ser_mode_r <= reg_wdata;
      if (wr_hit(`TSIU_OFS_TIMER_SETUP)) begin
        timer_setup_r[5:0] <= reg_wdata[5:0];
        timer_setup_r[7] <= reg_wdata[7];
        timer_setup_r[6] <= timer_setup_r[6] & reg_wdata[6];
      end
      if (ext2_ev) timer_setup_r[6] <= 1'b1;
      else if (int_ack && !(|live) && ext2_live) timer_setup_r[6] <= 1'b0;
      if (|live) begin
        case (pick)
          2'h0: int_vector <= `TSIU_VEC_EXT1;
          2'h1: int_vector <= `TSIU_VEC_TIMER3;
          2'h2: int_vector <= `TSIU_VEC_TIMER2;
          default: int_vector <= `TSIU_VEC_T1_SER;
        endcase
      end else begin
        int_vector <= `TSIU_VEC_EXT2_BRK;
      end
      if (int_ack) break_flag <= !(|live) && !ext2_live && break_instruction;
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `TSIU_OFS_EDGE_MODE: reg_rdata <= edge_mode_r;
          `TSIU_OFS_SER_MODE: reg_rdata <= ser_mode_r;
          `TSIU_OFS_SER_DATA: reg_rdata <= shift_r;
          `TSIU_OFS_TIMER1: reg_rdata <= cnt_r[0];
          `TSIU_OFS_TIMER2: reg_rdata <= cnt_r[1];
          `TSIU_OFS_TIMER3: reg_rdata <= cnt_r[2];
          `TSIU_OFS_INT_CTRL: reg_rdata <= int_ctrl_r;
          `TSIU_OFS_TIMER_SETUP: reg_rdata <= timer_setup_r;
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// >>> include/tsiu_defines.vh
// Constants for the timer, serial and interrupt unit.
`ifndef TSIU_DEFINES_VH
`define TSIU_DEFINES_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TSIU_OFS_EDGE_MODE 8'hF5
`define TSIU_OFS_SER_MODE 8'hF6
`define TSIU_OFS_SER_DATA 8'hF7
`define TSIU_OFS_TIMER1 8'hF9
`define TSIU_OFS_TIMER2 8'hFA
`define TSIU_OFS_TIMER3 8'hFB
`define TSIU_OFS_INT_CTRL 8'hFE
`define TSIU_OFS_TIMER_SETUP 8'hFF
// ----------------------------------------
// Field positions
// ----------------------------------------
`define TSIU_EXT1_POL_BIT 4
`define TSIU_EXT2_POL_BIT 5
`define TSIU_SM_CLKSEL_HI 1
`define TSIU_SM_CLKSEL_LO 0
`define TSIU_SM_SERIAL_EN_BIT 2
`define TSIU_SM_RDY_EN_BIT 3
`define TSIU_TS_T1_SRC_BIT 2
`define TSIU_TS_T2_SRC_BIT 3
`define TSIU_TS_T3_SRC_BIT 4
`define TSIU_TS_T2_HALT_BIT 5
// Interrupt control: request bits 0..3 and enables 4..7 in source order.
`define TSIU_IC_REQ_LO 0
`define TSIU_IC_EN_LO 4
// ----------------------------------------
// Reset values and vectors
// ----------------------------------------
`define TSIU_T2_LATCH_RST 8'hFF
`define TSIU_T3_LATCH_RST 8'h07
`define TSIU_SER_CNT_LOAD 3'h7
`define TSIU_REG_RST 8'h00
`define TSIU_VEC_RESET 16'hFFFE
`define TSIU_VEC_EXT1 16'hFFFC
`define TSIU_VEC_TIMER3 16'hFFFA
`define TSIU_VEC_TIMER2 16'hFFF8
`define TSIU_VEC_T1_SER 16'hFFF6
`define TSIU_VEC_EXT2_BRK 16'hFFF4
// ----------------------------------------
// Timing counts
// ----------------------------------------
`define TSIU_PHI_DIV 2'h3
`endif

// >>> tb/tb_tsiu_core.sv
// Self-checking bench for the timer, serial and interrupt unit.
`timescale 1ns/1ps
`include "tsiu_defines.vh"
module tb_tsiu_core;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rx_byte, v;
  logic reg_wr = 1'h0, reg_rd = 1'h0, disable_flag = 1'h1, break_instruction = 1'h0;
  logic int_ack = 1'h0, ext_one_pin = 1'h0, ext_two_pin = 1'h0, external_count_input = 1'h1;
  logic stop_instruction = 1'h0, ext_clk = 1'h1;
  logic [15:0] int_vector;
  logic int_pending, break_flag, set_disable, ser_clk_out, ser_clk_oe, ser_dout;
  logic ser_dout_oe, ser_rdy_n, ser_rdy_oe, ser_din;
  int bad_count = 0, num_checks = 0;
  // Address, write data, read mask and expected read value.
  logic [31:0] rows [5] = '{32'hF530FF30, 32'hF603FF03, 32'hFEFFF0F0, 32'hFF747F34, 32'hF055FF00};
  wire clk_pin = (ser_clk_oe === 1'h1) ? ser_clk_out : ext_clk;
  tsiu_core dut_u (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .disable_flag, .break_instruction, .stop_instruction, .int_ack, .int_pending,
    .int_vector, .break_flag, .set_disable, .ext_one_pin, .ext_two_pin, .external_count_input,
    .ser_clk_in(clk_pin), .ser_clk_out, .ser_clk_oe, .ser_din, .ser_dout, .ser_dout_oe,
    .ser_rdy_n, .ser_rdy_oe);
  tsiu_ser_partner peer_u (.clk_pin, .rx_line(ser_dout), .tx_line(ser_din),
    .tx_byte(8'h3C), .rx_byte);
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  task chk(input [16:0] got, input [16:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  task rd(input [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #2 v = reg_rdata;
  endtask
  task ack;
    @(posedge ref_clk);
    int_ack <= 1'h1;
    @(posedge ref_clk);
    int_ack <= 1'h0;
  endtask
  task pulses(input int n);
    repeat (n) begin
      @(posedge ref_clk) external_count_input <= 1'h0;
      tick(4);
      @(posedge ref_clk) external_count_input <= 1'h1;
      tick(4);
    end
  endtask
  task wait_pend(input int max);
    int i;
    i = 0;
    while (int_pending !== 1'h1 && i < max) begin
      @(posedge ref_clk);
      i++;
    end
    tick(1);
  endtask
  task give_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    give_verdict;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    chk(int_vector, `TSIU_VEC_RESET);
    chk({ser_rdy_n, break_flag}, 2'h2);
    rst <= 1'h0;
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      wr(rows[i][31:24], rows[i][23:16]);
      rd(rows[i][31:24]);
      chk(v & rows[i][15:8], rows[i][7:0]);
    end
    $display("register table done");
    wr(`TSIU_OFS_INT_CTRL, 8'hF0);
    wr(`TSIU_OFS_TIMER_SETUP, 8'hB4);
    @(posedge ref_clk) break_instruction <= 1'h1;
    tick(2);
    chk({int_pending, int_vector}, {1'h1, `TSIU_VEC_EXT2_BRK});
    ack;
    break_instruction <= 1'h0;
    tick(1);
    chk({int_pending, break_flag}, 2'h1);
    $display("break test done");
    @(posedge ref_clk) ext_two_pin <= 1'h1;
    tick(8);
    chk(int_pending, 1'h0);
    @(posedge ref_clk) disable_flag <= 1'h0;
    tick(2);
    chk({int_pending, int_vector}, {1'h1, `TSIU_VEC_EXT2_BRK});
    @(posedge ref_clk) ext_one_pin <= 1'h1;
    tick(8);
    chk({int_pending, int_vector}, {1'h1, `TSIU_VEC_EXT1});
    ack;
    tick(2);
    chk({int_pending, int_vector}, {1'h1, `TSIU_VEC_EXT2_BRK});
    ack;
    tick(2);
    chk({int_pending, break_flag}, 2'h0);
    @(posedge ref_clk) ext_one_pin <= 1'h0;
    tick(8);
    chk(int_pending, 1'h0);
    wr(`TSIU_OFS_EDGE_MODE, 8'h00);
    @(posedge ref_clk) ext_one_pin <= 1'h1;
    tick(8);
    chk(int_pending, 1'h0);
    @(posedge ref_clk) ext_one_pin <= 1'h0;
    tick(8);
    chk({int_pending, int_vector}, {1'h1, `TSIU_VEC_EXT1});
    ack;
    $display("pin edge test done");
    wr(`TSIU_OFS_TIMER3, 8'h07);
    repeat (2) begin
      pulses(6);
      chk(int_pending, 1'h0);
      pulses(2);
      chk({int_pending, int_vector}, {1'h1, `TSIU_VEC_TIMER3});
      ack;
    end
    $display("timer test done");
    wr(`TSIU_OFS_SER_MODE, 8'h0F);
    wr(`TSIU_OFS_INT_CTRL, 8'hF0);
    wr(`TSIU_OFS_SER_DATA, 8'hA5);
    wait_pend(300);
    chk({int_pending, int_vector}, {1'h1, `TSIU_VEC_T1_SER});
    chk(rx_byte, 8'hA5);
    rd(`TSIU_OFS_SER_DATA);
    chk(v, 8'h3C);
    ack;
    $display("serial test done");
    wr(`TSIU_OFS_SER_MODE, 8'h04);
    wr(`TSIU_OFS_SER_DATA, 8'h96);
    repeat (8) begin
      @(posedge ref_clk) ext_clk <= 1'h0;
      tick(8);
      @(posedge ref_clk) ext_clk <= 1'h1;
      tick(8);
    end
    tick(4);
    chk({int_pending, int_vector}, {1'h1, `TSIU_VEC_T1_SER});
    chk({ser_clk_oe, ser_dout_oe}, 2'h1);
    chk(rx_byte, 8'h96);
    rd(`TSIU_OFS_SER_DATA);
    chk(v, 8'h3C);
    ack;
    $display("external clock test done");
    wr(`TSIU_OFS_TIMER2, 8'h20);
    wr(`TSIU_OFS_INT_CTRL, 8'hB0);
    @(posedge ref_clk) stop_instruction <= 1'h1;
    @(posedge ref_clk) stop_instruction <= 1'h0;
    rd(`TSIU_OFS_TIMER3);
    chk(v, `TSIU_T3_LATCH_RST);
    wait_pend(9000);
    chk({int_pending, int_vector}, {1'h1, `TSIU_VEC_TIMER3});
    rd(`TSIU_OFS_TIMER2);
    chk(v, `TSIU_T2_LATCH_RST);
    ack;
    $display("stop chain test done");
    @(posedge ref_clk) rst <= 1'h1;
    tick(2);
    chk(int_vector, `TSIU_VEC_RESET);
    chk({ser_clk_oe, ser_dout_oe, ser_rdy_oe, ser_dout, reg_rdata}, 12'h100);
    @(posedge ref_clk) rst <= 1'h0;
    rd(`TSIU_OFS_TIMER3);
    chk(v, `TSIU_T3_LATCH_RST);
    rd(`TSIU_OFS_SER_MODE);
    chk(v, `TSIU_REG_RST);
    $display("second reset test done");
    give_verdict;
  end
endmodule

// >>> tb/tsiu_core_assertions.sv
// Port checker for the timer, serial and interrupt unit.
`timescale 1ns/1ps
`include "tsiu_defines.vh"
module tsiu_core_assertions (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  // CPU side
  input wire disable_flag,
  input wire break_instruction,
  input wire int_ack,
  input wire int_pending,
  input wire [15:0] int_vector,
  input wire break_flag,
  input wire set_disable,
  // Serial pins
  input wire ser_clk_out,
  input wire ser_clk_oe,
  input wire ser_dout_oe,
  input wire ser_rdy_n,
  input wire ser_rdy_oe
);
  reg [7:0] mode_r;
  reg [3:0] falls_r;
  reg clk_q_r;
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Shadow of the serial mode and a count of driven shift clock falls.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_r <= 8'h00;
      falls_r <= 4'h0;
      clk_q_r <= 1'h1;
    end else begin
      clk_q_r <= ser_clk_out;
      if (reg_wr && reg_addr == `TSIU_OFS_SER_MODE) mode_r <= reg_wdata;
      if (reg_wr && reg_addr == `TSIU_OFS_SER_DATA) falls_r <= 4'h0;
      else if (ser_clk_oe && clk_q_r && !ser_clk_out && falls_r != 4'hF) falls_r <= falls_r + 4'h1;
    end
  end
  a_ack_sets_disable:
    assert property (set_disable == int_ack) else $error("set_disable differs from ack");
  a_flag_holds_off:
    assert property (disable_flag && !break_instruction |-> !int_pending)
    else $error("interrupt pending while disabled");
  a_ack_break_flag:
    assert property (int_ack && (disable_flag || !break_instruction) |=>
      break_flag == $past(break_instruction))
    else $error("break flag wrong after ack");
  a_vector_in_table:
    assert property (int_vector[15:4] == 12'hFFF && !int_vector[0] && int_vector[3:0] >= 4'h4)
    else $error("vector outside table");
  a_dout_oe_mode:
    assert property (ser_dout_oe == mode_r[2]) else $error("data enable wrong");
  a_clk_oe_mode:
    assert property (ser_clk_oe == (mode_r[2] && mode_r[1])) else $error("clock enable wrong");
  a_ready_oe_mode:
    assert property (ser_rdy_oe == mode_r[3]) else $error("ready enable wrong");
  a_ready_low_write:
    assert property (ser_clk_oe && reg_wr && reg_addr == `TSIU_OFS_SER_DATA |=> !ser_rdy_n)
    else $error("ready not low after data write");
  a_ready_high_fall:
    assert property (ser_clk_oe && $fell(ser_clk_out) |-> ##[0:1] ser_rdy_n)
    else $error("ready not high after clock fall");
  a_eight_falls_max:
    assert property (falls_r <= 4'h8) else $error("more than eight shift clocks");
  a_clock_stays_high:
    assert property (ser_clk_oe && falls_r == 4'h8 && ser_clk_out && !reg_wr |=> ser_clk_out)
    else $error("shift clock did not stop high");
  c_serial_done: cover property (falls_r == 4'h8);
  c_break_taken: cover property (int_ack && break_instruction);
  c_ext_one_wins: cover property (int_pending && int_vector == `TSIU_VEC_EXT1);
endmodule
bind tsiu_core tsiu_core_assertions chk_u (
  .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .disable_flag, .break_instruction,
  .int_ack, .int_pending, .int_vector, .break_flag, .set_disable, .ser_clk_out,
  .ser_clk_oe, .ser_dout_oe, .ser_rdy_n, .ser_rdy_oe
);

// >>> tb/tsiu_ser_partner.sv
// Serial partner model that answers the shift clock with a fixed byte.
`timescale 1ns/1ps
module tsiu_ser_partner (
  // Link
  input wire clk_pin,
  input wire rx_line,
  output reg tx_line,
  // Bench side
  input wire [7:0] tx_byte,
  output reg [7:0] rx_byte
);
  reg [2:0] idx = 3'h0;
  initial tx_line = 1'h1;
  // The bit index moves on falling edges only, so a stray rise at start-up cannot skew it.
  always @(negedge clk_pin) begin
    tx_line <= tx_byte[idx];
    idx <= idx + 3'h1;
  end
  // The last bit stays on the line until the next frame starts.
  always @(posedge clk_pin) begin
    rx_byte <= {rx_line, rx_byte[7:1]};
  end
endmodule
